/* bench/boot_link_checker.sv */
// wire checks on both lines of the boot link
`timescale 1ns/100ps
`default_nettype none
module boot_link_checker #(
  parameter int BIT = 16
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic h2d,
  input wire logic d2h
);
  logic d_prev_q;
  logic h_prev_q;
  logic h_seen_q;
  logic d_seen_q;
  int d_run_q;
  int h_run_q;
  int h_low1_q;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      d_prev_q <= 1'b1;
      h_prev_q <= 1'b1;
      h_seen_q <= 1'b0;
      d_seen_q <= 1'b0;
      d_run_q <= 0;
      h_run_q <= 0;
      h_low1_q <= 0;
    end else begin
      d_prev_q <= d2h;
      h_prev_q <= h2d;
      d_run_q <= (d2h != d_prev_q) ? 1 : d_run_q + 1;
      h_run_q <= (h2d != h_prev_q) ? 1 : h_run_q + 1;
      if (!h2d) h_seen_q <= 1'b1;
      if (d2h && !d_prev_q) d_seen_q <= 1'b1;
      // first low run carries the shape of the sync byte
      if (h2d && !h_prev_q && h_low1_q == 0) h_low1_q <= h_run_q;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  sequence d_rise; d2h && !d_prev_q; endsequence
  sequence d_fall; !d2h && d_prev_q; endsequence
  sequence h_rise; h2d && !h_prev_q; endsequence
  sequence h_fall; !h2d && h_prev_q && h_seen_q; endsequence
  sequence h_first; !h2d && h_prev_q && !h_seen_q; endsequence
  // a zero byte gives the longest low run: start plus eight bits
  dev_low_run_a: assert property (d_rise |-> d_run_q % BIT == 0 && d_run_q <= 9 * BIT)
    else $error("device low run off bit grid");
  dev_high_run_a: assert property (d_fall |-> d_run_q >= BIT)
    else $error("device high run too short");
  host_low_run_a: assert property (h_rise |-> h_run_q % BIT == 0 && h_run_q <= 9 * BIT)
    else $error("host low run off bit grid");
  host_high_run_a: assert property (h_fall |-> h_run_q >= BIT)
    else $error("host high run too short");
  silent_start_a: assert property (!h_seen_q |-> d2h)
    else $error("device sent before host");
  half_duplex_a: assert property (!d2h |-> h2d)
    else $error("both ends sending");
  sync_echo_at_a: assert property (h_first |-> ##[150:160] d_fall)
    else $error("sync echo late");
  sync_echo_val_a: assert property ((d_rise and !d_seen_q) |-> d_run_q == h_low1_q)
    else $error("sync echo differs");
endmodule // boot_link_checker
`default_nettype wire

/* bench/tb.sv */
// bench: host end talks to device end over the boot link
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic tx_valid_i = 1'b0;
  logic [7:0] tx_data_i = 8'h00;
  logic [1:0] reply_n_i = 2'h0;
  logic [23:0] cmp_addr = 24'h00FFE0;
  logic pw_blank_i = 1'b0;
  logic security_en_i = 1'b0;
  logic flash_ready_i = 1'b1;
  logic flash_blank_i = 1'b1;
  logic [15:0] flash_sum_i = 16'h1234;
  logic [15:0] rep [0:3];
  logic [15:0] ram_addr_o, jump_addr_o, first_addr;
  logic [7:0] pw_idx_o, rx_data_o, ram_wdata_o, first_data;
  logic tx_ready_o, rx_valid_o, rx_err_o, tmo_o, ram_we_o, jump_o, lock_o;
  logic [7:0] rec [0:12] = '{8'h3A, 8'h02, 8'h00, 8'h10, 8'h00, 8'h11, 8'h22, 8'hBB,
    8'h3A, 8'h00, 8'h00, 8'h00, 8'h01};
  int num_errors = 0, compares = 0, rep_n = 0, tot_rep = 0, wr_n = 0, jmp_n = 0, tmo_n = 0, i, k;
  always #2 clk_sys_i = ~clk_sys_i;
  boot_link_if link ();
  boot_host #(.BIT_CYCLES(16'h0010), .TMO_CYCLES(800)) u_boot_host (.clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i), .link(link), .tx_valid_i(tx_valid_i), .tx_data_i(tx_data_i),
    .reply_n_i(reply_n_i), .tx_ready_o(tx_ready_o), .rx_valid_o(rx_valid_o),
    .rx_data_o(rx_data_o), .rx_err_o(rx_err_o), .tmo_o(tmo_o));
  // password bytes follow the index: C0, C1
  boot_dev u_boot_dev (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .link(link),
    .pw_cnt_addr_i(24'h00FFDF), .pw_cmp_addr_i(cmp_addr), .pw_blank_i(pw_blank_i),
    .pw_len_i(8'h02), .pw_byte_i(8'hC0 + pw_idx_o), .pw_idx_o(pw_idx_o),
    .security_en_i(security_en_i), .flash_ready_i(flash_ready_i),
    .flash_blank_i(flash_blank_i), .flash_sum_i(flash_sum_i), .ram_we_o(ram_we_o),
    .ram_addr_o(ram_addr_o), .ram_wdata_o(ram_wdata_o), .jump_o(jump_o),
    .jump_addr_o(jump_addr_o), .lock_o(lock_o));
  boot_link_checker #(.BIT(16)) u_chk (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .h2d(link.h2d), .d2h(link.d2h));
  always @(posedge clk_sys_i) begin
    if (rx_valid_o === 1'b1) begin
      // a stop-bit error shows up as bit 8 of the stored reply
      rep[rep_n] = {7'h00, rx_err_o, rx_data_o};
      rep_n++;
      tot_rep++;
    end
    if (ram_we_o === 1'b1) begin
      if (wr_n == 0) first_addr = ram_addr_o;
      if (wr_n == 0) first_data = ram_wdata_o;
      wr_n++;
    end
    if (jump_o === 1'b1) jmp_n++;
    if (tmo_o === 1'b1) tmo_n++;
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // bounded: tx_ready_o stuck low ends the run instead of hanging; a lost reply is ended by the host timeout
  task automatic wait_ready;
    int n;
    for (n = 0; n < 5000 && tx_ready_o !== 1'b1; n++) begin
      @(posedge clk_sys_i);
      #1;
    end
    if (n == 5000) begin
      num_errors++;
      $display("[FAIL] tx_ready_o expected 1 seen %b", tx_ready_o);
      complete_run();
    end
  endtask
  task automatic xfer(input logic [7:0] d, input logic [1:0] n);
    wait_ready();
    rep_n = 0;
    tx_data_i = d;
    reply_n_i = n;
    tx_valid_i = 1'b1;
    @(posedge clk_sys_i);
    #1;
    tx_valid_i = 1'b0;
    wait_ready();
  endtask
  task automatic expect3(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    check("reply count", 16'(rep_n), 16'h0003);
    check("reply 0", rep[0], a);
    check("reply 1", rep[1], b);
    check("reply 2", rep[2], c);
  endtask
  task automatic start(input logic [7:0] s1, input logic [7:0] s2);
    logic [15:0] e2;
    arst_n_i = 1'b0;
    tot_rep = 0;
    tmo_n = 0;
    wr_n = 0;
    jmp_n = 0;
    repeat (6) @(posedge clk_sys_i);
    #1;
    arst_n_i = 1'b1;
    xfer(s1, 2'h1);
    check("sync1 echo", rep[0], {8'h00, s1});
    xfer(s2, 2'h1);
    e2 = (s2 == 8'h79 || s2 == 8'hCF) ? {8'h00, s2} : 16'h0000;
    check("sync2 echo", (rep_n > 0) ? rep[0] : 16'h0000, e2);
  endtask
  task automatic send_addr;
    logic [47:0] a;
    a = 48'h00FFDF00FFE0;
    for (int j = 0; j < 6; j++) xfer(a[47 - 8 * j -: 8], 2'h0);
  endtask
  initial begin
    start(8'h86, 8'hCF);
    xfer(8'h90, 2'h3);
    expect3(16'h00AA, 16'h0012, 16'h0034);
    flash_blank_i = 1'b0;
    flash_sum_i = 16'hABCD;
    xfer(8'h90, 2'h3);
    expect3(16'h0055, 16'h00AB, 16'h00CD);
    xfer(8'h11, 2'h3);
    expect3(16'h0063, 16'h0063, 16'h0063);
    $display("test flash_sum done");
    start(8'h30, 8'h79);
    xfer(8'h60, 2'h1);
    check("load echo", rep[0], 16'h0060);
    send_addr();
    xfer(8'hC0, 2'h0);
    xfer(8'hC1, 2'h0);
    check("silent phase", 16'(tot_rep), 16'h0003);
    for (i = 0; i < 13; i++) xfer(rec[i], 2'h0);
    xfer(8'hFF, 2'h2);
    check("sum hi", rep[0], 16'h0000);
    check("sum lo", rep[1], 16'h0033);
    repeat (40) @(posedge clk_sys_i);
    check("writes", 16'(wr_n), 16'h0002);
    check("first addr", first_addr, 16'h0010);
    check("first data", {8'h00, first_data}, 16'h0011);
    check("jumps", 16'(jmp_n), 16'h0001);
    check("jump addr", jump_addr_o, 16'h0010);
    $display("test ram_load done");
    pw_blank_i = 1'b1;
    // k 2: blank area, right addresses, records follow with no password
    for (k = 0; k < 3; k++) begin
      security_en_i = (k == 1);
      cmp_addr = (k == 0) ? 24'h00FFE1 : 24'h00FFE0;
      start(8'h86, 8'h79);
      xfer(8'h60, 2'h1);
      send_addr();
      if (k == 2) for (i = 0; i < 8; i++) xfer(rec[i], 2'h0);
      repeat (20) @(posedge clk_sys_i);
      check("lock", {15'h0000, lock_o}, (k < 2) ? 16'h0001 : 16'h0000);
      check("no reply", 16'(tot_rep), 16'h0003);
      if (k == 2) check("blank writes", 16'(wr_n), 16'h0002);
    end
    $display("test lock done");
    flash_ready_i = 1'b0;
    security_en_i = 1'b0;
    start(8'h30, 8'hCF);
    xfer(8'h90, 2'h3);
    expect3(16'h00A3, 16'h00A3, 16'h00A3);
    $display("test not_ready done");
    flash_ready_i = 1'b1;
    start(8'h30, 8'h5A);
    repeat (2) @(posedge clk_sys_i);
    check("sync2 lock", {15'h0000, lock_o}, 16'h0001);
    check("timeouts", 16'(tmo_n), 16'h0001);
    $display("test bad_sync2 done");
    complete_run();
  end
endmodule // tb
`default_nettype wire

/* design/boot_dev.sv */
// device end: serial boot command handler for ram load and flash checksum
`include "boot_loader_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module boot_dev (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  boot_link_if.dev link,
  input wire logic [23:0] pw_cnt_addr_i,
  input wire logic [23:0] pw_cmp_addr_i,
  input wire logic pw_blank_i,
  input wire logic [7:0] pw_len_i,
  input wire logic [7:0] pw_byte_i,
  output logic [7:0] pw_idx_o,
  input wire logic security_en_i,
  input wire logic flash_ready_i,
  input wire logic flash_blank_i,
  input wire logic [15:0] flash_sum_i,
  output logic ram_we_o,
  output logic [15:0] ram_addr_o,
  output logic [7:0] ram_wdata_o,
  output logic jump_o,
  output logic [15:0] jump_addr_o,
  output logic lock_o
);
  boot_loader_pkg::dev_state_t st_q, after_q;
  logic [15:0] bit_q, meas_q, lo_q, tail_q;
  logic [7:0] q_q [3];
  logic [1:0] q_n_q, q_i_q;
  logic tx_go_q, tx_busy, rx_valid, rx_err;
  logic [7:0] tx_data_q, rx_data;
  logic [47:0] addr_sh_q;
  logic [4:0] cnt_q;
  logic [7:0] pw_idx_q, rec_len_q, rec_sum_q;
  logic [2:0] rec_pos_q;
  logic [15:0] rec_addr_q, load_sum_q, first_addr_q;
  logic first_seen_q, we_q, jump_q;
  logic [7:0] wdata_q;
  logic [17:0] lo_x2, hi_x3;
  logic is_sync1_b, baud_ok;
  logic [15:0] bit_est, tail_est;
  logic [7:0] rec_sum_nx;
  logic [7:0] err_code;

  serial_frame u_frame (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .bit_cycles_i(bit_q),
    .rx_en_i(st_q != boot_loader_pkg::DEV_BAUD_LO && st_q != boot_loader_pkg::DEV_BAUD_HI
             && st_q != boot_loader_pkg::DEV_BAUD_TAIL),
    .rxd_i(link.h2d),
    .tx_start_i(tx_go_q),
    .tx_data_i(tx_data_q),
    .txd_o(link.d2h),
    .tx_busy_o(tx_busy),
    .rx_valid_o(rx_valid),
    .rx_data_o(rx_data),
    .rx_err_o(rx_err)
  );

  // ----------------------------------------------------------------
  // baud estimate from the first byte
  // ----------------------------------------------------------------
  // 0x86 starts with 2 low then 2 high bits, 0x30 with 5 low then 2 high
  always_comb begin
    lo_x2 = {1'b0, lo_q, 1'b0};
    hi_x3 = {2'b00, meas_q} + {1'b0, meas_q, 1'b0};
    is_sync1_b = lo_x2 > hi_x3;
    bit_est = is_sync1_b ? lo_q / 16'd5 : lo_q >> 1;
    tail_est = is_sync1_b ? 16'((bit_est << 1) + (bit_est >> 1))
                          : 16'((bit_est << 2) + bit_est + (bit_est >> 1));
    // ratio must fit one of the two patterns, otherwise stay silent
    baud_ok = (bit_est != 16'h0000) && (is_sync1_b || ({2'b00, meas_q} << 1) <= {2'b00, lo_q}
              + {1'b0, lo_q, 1'b0});
    rec_sum_nx = rec_sum_q + rx_data;
    // a frame error outranks the command code, which may itself be corrupt
    err_code = rx_err ? `ERR_RX : (rx_data == `CMD_FLASH_SUM) ? `ERR_FLASH : `ERR_CMD;
  end

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= boot_loader_pkg::DEV_BAUD_LO;
      after_q <= boot_loader_pkg::DEV_LOCK;
      bit_q <= 16'h0001;
      meas_q <= 16'h0000;
      lo_q <= 16'h0000;
      tail_q <= 16'h0000;
      q_q <= '{8'h00, 8'h00, 8'h00};
      q_n_q <= 2'd0;
      q_i_q <= 2'd0;
      tx_go_q <= 1'b0;
      tx_data_q <= 8'h00;
      addr_sh_q <= 48'h0;
      cnt_q <= 5'd0;
      pw_idx_q <= 8'h00;
      jump_q <= 1'b0;
    end else begin
      tx_go_q <= 1'b0;
      jump_q <= 1'b0;
      case (st_q)
        boot_loader_pkg::DEV_BAUD_LO: begin
          if (!link.h2d) begin
            meas_q <= meas_q + 16'h0001;
          end else if (meas_q != 16'h0000) begin
            lo_q <= meas_q;
            meas_q <= 16'h0001;
            st_q <= boot_loader_pkg::DEV_BAUD_HI;
          end
        end
        boot_loader_pkg::DEV_BAUD_HI: begin
          if (link.h2d) begin
            meas_q <= meas_q + 16'h0001;
          end else if (baud_ok) begin
            bit_q <= bit_est;
            tail_q <= tail_est;
            q_q[0] <= is_sync1_b ? `SYNC1_B : `SYNC1_A;
            st_q <= boot_loader_pkg::DEV_BAUD_TAIL;
          end else begin
            meas_q <= 16'h0000;
            st_q <= boot_loader_pkg::DEV_BAUD_LO;
          end
        end
        boot_loader_pkg::DEV_BAUD_TAIL: begin
          if (tail_q != 16'h0000) begin
            tail_q <= tail_q - 16'h0001;
          end else if (link.h2d) begin
            q_n_q <= 2'd1;
            q_i_q <= 2'd0;
            after_q <= boot_loader_pkg::DEV_SYNC2;
            st_q <= boot_loader_pkg::DEV_SEND;
          end else begin
            meas_q <= 16'h0000;
            st_q <= boot_loader_pkg::DEV_BAUD_LO;
          end
        end
        boot_loader_pkg::DEV_SYNC2: begin
          if (rx_valid) begin
            if (!rx_err && (rx_data == `SYNC2_A || rx_data == `SYNC2_B)) begin
              q_q[0] <= rx_data;
              q_n_q <= 2'd1;
              q_i_q <= 2'd0;
              after_q <= boot_loader_pkg::DEV_CMD;
              st_q <= boot_loader_pkg::DEV_SEND;
            end else begin
              st_q <= boot_loader_pkg::DEV_LOCK;
            end
          end
        end
        boot_loader_pkg::DEV_CMD: begin
          if (rx_valid) begin
            q_i_q <= 2'd0;
            st_q <= boot_loader_pkg::DEV_SEND;
            cnt_q <= 5'd0;
            if (rx_err || (rx_data != `CMD_RAM_LOAD && rx_data != `CMD_FLASH_SUM)
                || (rx_data == `CMD_FLASH_SUM && !flash_ready_i)) begin
              q_q <= '{err_code, err_code, err_code};
              q_n_q <= `ERR_REPEAT;
              after_q <= boot_loader_pkg::DEV_LOCK;
            end else if (rx_data == `CMD_RAM_LOAD) begin
              q_q[0] <= `CMD_RAM_LOAD;
              q_n_q <= 2'd1;
              after_q <= boot_loader_pkg::DEV_ADDR;
            end else begin
              // no echo: the blank flag leads the answer
              q_q <= '{flash_blank_i ? `SUM_ALL_BLANK : `SUM_NOT_BLANK,
                       flash_sum_i[15:8], flash_sum_i[7:0]};
              q_n_q <= 2'd3;
              after_q <= boot_loader_pkg::DEV_CMD;
            end
          end
        end
        boot_loader_pkg::DEV_ADDR: begin
          if (rx_valid) begin
            if (rx_err) begin
              st_q <= boot_loader_pkg::DEV_LOCK;
            end else begin
              addr_sh_q <= {addr_sh_q[39:0], rx_data};
              cnt_q <= cnt_q + 5'd1;
            end
          end else if (cnt_q == `PW_ADDR_BYTES) begin
            pw_idx_q <= 8'h00;
            if (security_en_i || addr_sh_q[47:24] != pw_cnt_addr_i
                || addr_sh_q[23:0] != pw_cmp_addr_i) begin
              st_q <= boot_loader_pkg::DEV_LOCK;
            end else if (pw_blank_i || pw_len_i == 8'h00) begin
              st_q <= boot_loader_pkg::DEV_REC;
            end else begin
              st_q <= boot_loader_pkg::DEV_PW;
            end
          end
        end
        boot_loader_pkg::DEV_PW: begin
          if (rx_valid) begin
            if (rx_err || rx_data != pw_byte_i) begin
              st_q <= boot_loader_pkg::DEV_LOCK;
            end else if (pw_idx_q == pw_len_i - 8'h01) begin
              st_q <= boot_loader_pkg::DEV_REC;
            end
            pw_idx_q <= pw_idx_q + 8'h01;
          end
        end
        boot_loader_pkg::DEV_REC: begin
          if (rx_valid) begin
            // bad mark, bad record checksum or bad frame: answer nothing
            if (rx_err || (rec_pos_q == 3'd0 && rx_data != `HEX_MARK)
                || (rec_pos_q == 3'd6 && rec_sum_nx != 8'h00)) begin
              st_q <= boot_loader_pkg::DEV_LOCK;
            end else if (rec_pos_q == 3'd6 && rec_len_q == 8'h00 && rx_data != 8'h00
                         && addr_sh_q[7:0] == `HEX_TYPE_END) begin
              q_q[0] <= load_sum_q[15:8];
              q_q[1] <= load_sum_q[7:0];
              q_n_q <= 2'd2;
              q_i_q <= 2'd0;
              after_q <= boot_loader_pkg::DEV_JUMP;
              st_q <= boot_loader_pkg::DEV_SEND;
            end else if (rec_pos_q == 3'd4) begin
              addr_sh_q[7:0] <= rx_data;
            end
          end
        end
        boot_loader_pkg::DEV_SEND: begin
          if (!tx_go_q && !tx_busy) begin
            if (q_i_q != q_n_q) begin
              tx_data_q <= q_q[q_i_q];
              tx_go_q <= 1'b1;
              q_i_q <= q_i_q + 2'd1;
            end else begin
              st_q <= after_q;
            end
          end
        end
        boot_loader_pkg::DEV_JUMP: begin
          jump_q <= 1'b1;
          st_q <= boot_loader_pkg::DEV_LOCK;
        end
        default: begin
          st_q <= boot_loader_pkg::DEV_LOCK;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // hex record walker and ram write port
  // ----------------------------------------------------------------
  // the end record's type byte is kept in addr_sh_q[7:0] by the sequencer
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rec_pos_q <= 3'd0;
      rec_len_q <= 8'h00;
      rec_sum_q <= 8'h00;
      rec_addr_q <= 16'h0000;
      load_sum_q <= 16'h0000;
      first_addr_q <= 16'h0000;
      first_seen_q <= 1'b0;
      we_q <= 1'b0;
      wdata_q <= 8'h00;
    end else begin
      we_q <= 1'b0;
      if (st_q == boot_loader_pkg::DEV_REC && rx_valid && !rx_err) begin
        rec_sum_q <= (rec_pos_q == 3'd0) ? 8'h00 : rec_sum_nx;
        case (rec_pos_q)
          3'd0: rec_pos_q <= 3'd1;
          3'd1: begin
            rec_len_q <= rx_data;
            rec_pos_q <= 3'd2;
          end
          3'd2: begin
            rec_addr_q[15:8] <= rx_data;
            rec_pos_q <= 3'd3;
          end
          3'd3: begin
            rec_addr_q[7:0] <= rx_data;
            rec_pos_q <= 3'd4;
          end
          3'd4: rec_pos_q <= (rec_len_q == 8'h00) ? 3'd6 : 3'd5;
          3'd5: begin
            we_q <= 1'b1;
            wdata_q <= rx_data;
            load_sum_q <= load_sum_q + {8'h00, rx_data};
            rec_addr_q <= rec_addr_q + 16'h0001;
            rec_len_q <= rec_len_q - 8'h01;
            if (!first_seen_q) begin
              first_seen_q <= 1'b1;
              first_addr_q <= rec_addr_q;
            end
            if (rec_len_q == 8'h01) begin
              rec_pos_q <= 3'd6;
            end
          end
          default: rec_pos_q <= 3'd0;
        endcase
      end
    end
  end

  assign ram_we_o = we_q;
  assign ram_addr_o = rec_addr_q - 16'h0001;
  assign ram_wdata_o = wdata_q;
  assign jump_o = jump_q;
  assign jump_addr_o = first_addr_q;
  assign pw_idx_o = pw_idx_q;
  assign lock_o = (st_q == boot_loader_pkg::DEV_LOCK);
endmodule // boot_dev
`default_nettype wire

/* design/boot_host.sv */
// controller end: sends bytes at a fixed baud and collects the replies
`include "boot_loader_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module boot_host #(
  parameter logic [15:0] BIT_CYCLES = 16'(`HOST_BIT_CYCLES),
  parameter int TMO_CYCLES = `HOST_TMO_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  boot_link_if.host link,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  input wire logic [1:0] reply_n_i,
  output logic tx_ready_o,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_err_o,
  output logic tmo_o
);
  boot_loader_pkg::host_state_t st_q;
  logic [1:0] left_q;
  logic go_q, tmo_q, busy;
  logic [7:0] data_q;
  logic [31:0] wait_q;

  serial_frame u_frame (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .bit_cycles_i(BIT_CYCLES),
    .rx_en_i(1'b1),
    .rxd_i(link.d2h),
    .tx_start_i(go_q),
    .tx_data_i(data_q),
    .txd_o(link.h2d),
    .tx_busy_o(busy),
    .rx_valid_o(rx_valid_o),
    .rx_data_o(rx_data_o),
    .rx_err_o(rx_err_o)
  );

  // ----------------------------------------------------------------
  // one byte out, then hold off until its replies are in
  // ----------------------------------------------------------------
  // a silent device (failed sync, lock) is released by the timeout only
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= boot_loader_pkg::HOST_IDLE;
      left_q <= 2'd0;
      go_q <= 1'b0;
      tmo_q <= 1'b0;
      data_q <= 8'h00;
      wait_q <= 32'h0;
    end else begin
      go_q <= 1'b0;
      tmo_q <= 1'b0;
      case (st_q)
        boot_loader_pkg::HOST_IDLE: begin
          if (tx_valid_i) begin
            data_q <= tx_data_i;
            left_q <= reply_n_i;
            go_q <= 1'b1;
            st_q <= boot_loader_pkg::HOST_SEND;
          end
        end
        boot_loader_pkg::HOST_SEND: begin
          wait_q <= 32'h0;
          if (!go_q && !busy) begin
            st_q <= (left_q == 2'd0) ? boot_loader_pkg::HOST_IDLE
                                     : boot_loader_pkg::HOST_WAIT;
          end
        end
        boot_loader_pkg::HOST_WAIT: begin
          wait_q <= wait_q + 32'h1;
          if (rx_valid_o) begin
            left_q <= left_q - 2'd1;
            wait_q <= 32'h0;
            if (left_q == 2'd1) begin
              st_q <= boot_loader_pkg::HOST_IDLE;
            end
          end else if (wait_q == 32'(TMO_CYCLES)) begin
            tmo_q <= 1'b1;
            st_q <= boot_loader_pkg::HOST_IDLE;
          end
        end
        default: st_q <= boot_loader_pkg::HOST_IDLE;
      endcase
    end
  end

  assign tx_ready_o = (st_q == boot_loader_pkg::HOST_IDLE);
  assign tmo_o = tmo_q;
endmodule // boot_host
`default_nettype wire

/* design/boot_link_if.sv */
// two-wire asynchronous serial link between programming controller and device
`timescale 1ns/100ps
`default_nettype none
interface boot_link_if;
  logic h2d;
  logic d2h;
  modport dev (input h2d, output d2h);
  modport host (output h2d, input d2h);
endinterface
`default_nettype wire

/* design/boot_loader_defs.svh */
// constants shared by both ends of the serial boot link
`ifndef BOOT_LOADER_DEFS_SVH
`define BOOT_LOADER_DEFS_SVH
// ----------------------------------------------------------------
// protocol bytes
// ----------------------------------------------------------------
`define SYNC1_A 8'h86
`define SYNC1_B 8'h30
`define SYNC2_A 8'h79
`define SYNC2_B 8'hCF
`define CMD_RAM_LOAD 8'h60
`define CMD_FLASH_SUM 8'h90
`define ERR_RX 8'hA1
`define ERR_FLASH 8'hA3
`define ERR_CMD 8'h63
`define ERR_REPEAT 2'd3
`define SUM_ALL_BLANK 8'hAA
`define SUM_NOT_BLANK 8'h55
`define HEX_MARK 8'h3A
`define HEX_TYPE_END 8'h01
`define PW_ADDR_BYTES 5'd6
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_HZ 250000000
`define HOST_BAUD_HZ 115200
`define HOST_BIT_CYCLES (`CLK_HZ / `HOST_BAUD_HZ)
`define REPLY_TMO_BITS 40
`define HOST_TMO_CYCLES (`HOST_BIT_CYCLES * `REPLY_TMO_BITS)
`endif

/* design/boot_loader_pkg.sv */
// state types of the serial boot link ends
package boot_loader_pkg;
  typedef enum logic [3:0] {
    DEV_BAUD_LO, DEV_BAUD_HI, DEV_BAUD_TAIL, DEV_SYNC2, DEV_CMD, DEV_ADDR,
    DEV_PW, DEV_REC, DEV_SEND, DEV_JUMP, DEV_LOCK
  } dev_state_t;
  typedef enum logic [1:0] {
    HOST_IDLE, HOST_SEND, HOST_WAIT
  } host_state_t;
endpackage

/* design/serial_frame.sv */
// one start bit, eight data bits lsb first, one stop bit; bit time set at run time
`timescale 1ns/100ps
`default_nettype none
module serial_frame (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic [15:0] bit_cycles_i,
  input wire logic rx_en_i,
  input wire logic rxd_i,
  input wire logic tx_start_i,
  input wire logic [7:0] tx_data_i,
  output logic txd_o,
  output logic tx_busy_o,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_err_o
);
  logic rx_act_q, tx_act_q, txd_q, rx_valid_q, rx_err_q;
  logic [15:0] rx_cnt_q, tx_cnt_q;
  logic [3:0] rx_bit_q, tx_bit_q;
  logic [7:0] rx_sh_q, rx_data_q, tx_sh_q;

  // ----------------------------------------------------------------
  // receiver, sampling mid-bit
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_act_q <= 1'b0;
      rx_cnt_q <= 16'h0000;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 8'h00;
      rx_data_q <= 8'h00;
      rx_valid_q <= 1'b0;
      rx_err_q <= 1'b0;
    end else begin
      rx_valid_q <= 1'b0;
      if (!rx_act_q) begin
        if (rx_en_i && !rxd_i) begin
          rx_act_q <= 1'b1;
          rx_cnt_q <= bit_cycles_i >> 1;
          rx_bit_q <= 4'h0;
        end
      end else if (rx_cnt_q != 16'h0000) begin
        rx_cnt_q <= rx_cnt_q - 16'h0001;
      end else begin
        rx_cnt_q <= bit_cycles_i - 16'h0001;
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q == 4'h0) begin
          // a glitch shorter than half a bit is not a start bit
          if (rxd_i) begin
            rx_act_q <= 1'b0;
          end
        end else if (rx_bit_q == 4'h9) begin
          rx_act_q <= 1'b0;
          rx_valid_q <= 1'b1;
          rx_err_q <= !rxd_i;
          rx_data_q <= rx_sh_q;
        end else begin
          rx_sh_q <= {rxd_i, rx_sh_q[7:1]};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_act_q <= 1'b0;
      txd_q <= 1'b1;
      tx_cnt_q <= 16'h0000;
      tx_bit_q <= 4'h0;
      tx_sh_q <= 8'h00;
    end else if (!tx_act_q) begin
      if (tx_start_i) begin
        tx_act_q <= 1'b1;
        txd_q <= 1'b0;
        tx_sh_q <= tx_data_i;
        tx_cnt_q <= bit_cycles_i - 16'h0001;
        tx_bit_q <= 4'h0;
      end
    end else if (tx_cnt_q != 16'h0000) begin
      tx_cnt_q <= tx_cnt_q - 16'h0001;
    end else if (tx_bit_q == 4'h9) begin
      tx_act_q <= 1'b0;
    end else begin
      // the ninth shift puts the stop bit on the line
      txd_q <= (tx_bit_q == 4'h8) ? 1'b1 : tx_sh_q[0];
      tx_sh_q <= {1'b1, tx_sh_q[7:1]};
      tx_bit_q <= tx_bit_q + 4'h1;
      tx_cnt_q <= bit_cycles_i - 16'h0001;
    end
  end

  assign txd_o = txd_q;
  assign tx_busy_o = tx_act_q;
  assign rx_valid_o = rx_valid_q;
  assign rx_data_o = rx_data_q;
  assign rx_err_o = rx_err_q;
endmodule // serial_frame
`default_nettype wire
